// File: logic/bsc_pkg.sv
// package: constants and carriers for the six-step commutation block
package bsc_pkg;
	localparam int PWM_W = 12;
	localparam int TIM_W = 8;
	localparam int PRE_W = 4;
	localparam int DT_W = 8;
	localparam int NCH = 6;
	localparam logic [PRE_W-1:0] PRESCALE_RST = 4'h0;
	localparam logic [PRE_W-1:0] PRESCALE_MAX = 4'hf;
	localparam logic [TIM_W-1:0] TIMER_RST = 8'h00;
	localparam logic [TIM_W-1:0] TIMER_TOP = 8'hff;
	localparam logic [TIM_W-1:0] AUTO_HALF = 8'h80;
	localparam logic [TIM_W-1:0] AUTO_LOW = 8'h40;
	localparam logic [PWM_W-1:0] PWM_CNT_RST = 12'h000;
	localparam logic [7:0] REP_RST = 8'h00;
	localparam logic [DT_W-1:0] DT_RST = 8'h00;
	localparam logic [7:0] CHOP_RST = 8'h00;
	localparam logic [1:0] SEL_A = 2'h0;
	localparam logic [1:0] SEL_B = 2'h1;
	localparam logic [1:0] SEL_C = 2'h2;
	localparam logic [1:0] SAFE_HIZ = 2'h0;
	localparam logic [1:0] SAFE_LOW = 2'h1;
	localparam logic [1:0] SAFE_HIGH = 2'h2;
	localparam logic [NCH-1:0] PHASE_OE_RST = 6'h00;

	typedef struct packed {
		logic [NCH-1:0] phase_output_enables;
		logic [1:0] sense_input_select;
		logic zero_cross_edge_polarity;
		logic zero_voltage_detect_mode;
		logic [1:0] demag_control_pair;
	} bsc_phase_state_s;

	typedef struct packed {
		logic [NCH-1:0] polarity;
		logic [1:0] pwm_route;
		logic route_alternate;
		logic chop_enable;
		logic [7:0] chop_half_period;
		logic [DT_W-1:0] deadtime;
	} bsc_chan_cfg_s;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_WAIT_Z,
		SEQ_DELAY,
		SEQ_WAIT_D
	} bsc_seq_e;
endpackage : bsc_pkg

// File: logic/bsc_pwm_gen.sv
// three-phase pwm generator with preloaded compares and repetition
`timescale 1ns/1ns
module bsc_pwm_gen #(
	parameter int W = bsc_pkg::PWM_W
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// configuration
	input wire logic center_i,
	input wire logic [W-1:0] period_i,
	input wire logic [7:0] repeat_i,
	input wire logic [3*W-1:0] cmp_pre_i,
	// outputs
	output logic [2:0] ref_o,
	output logic update_o
);
	logic [W-1:0] cnt_reg, cnt_next;
	logic down_reg, down_next;
	logic [7:0] rep_reg, rep_next;
	logic [3*W-1:0] cmp_reg, cmp_next;
	logic [2:0] ref_next;
	logic upd_next;
	logic period_end;

	always_comb begin
		cnt_next = cnt_reg;
		down_next = down_reg;
		period_end = 1'b0;
		if (period_i == '0) begin
			cnt_next = '0;
			down_next = 1'b0;
			period_end = 1'b1;
		end else if (!center_i) begin
			down_next = 1'b0;
			if (cnt_reg >= period_i) begin
				cnt_next = '0;
				period_end = 1'b1;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end else if (!down_reg) begin
			if (cnt_reg >= period_i) begin
				down_next = 1'b1;
				cnt_next = cnt_reg - 1'b1;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end else if (cnt_reg == '0) begin
			down_next = 1'b0;
			cnt_next = cnt_reg + 1'b1;
			period_end = 1'b1;
		end else begin
			cnt_next = cnt_reg - 1'b1;
		end
		upd_next = period_end && (rep_reg == '0);
		rep_next = rep_reg;
		if (period_end) begin
			rep_next = (rep_reg == '0) ? repeat_i : rep_reg - 1'b1;
		end
		cmp_next = upd_next ? cmp_pre_i : cmp_reg;
		// compare above the period gives 100%, zero gives 0%
		for (int k = 0; k < 3; k++) begin
			ref_next[k] = cnt_next < cmp_next[k*W +: W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= bsc_pkg::PWM_CNT_RST;
			down_reg <= 1'b0;
			rep_reg <= bsc_pkg::REP_RST;
			cmp_reg <= '0;
			ref_o <= 3'h0;
			update_o <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			down_reg <= down_next;
			rep_reg <= rep_next;
			cmp_reg <= cmp_next;
			ref_o <= ref_next;
			update_o <= upd_next;
		end
	end
endmodule : bsc_pwm_gen

// File: logic/bsc_delay_timer.sv
// 8-bit delay timer with prescaler, two captures, clear on capture
`timescale 1ns/1ns
module bsc_delay_timer (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic run_i,
	input wire logic auto_i,
	input wire logic [bsc_pkg::PRE_W-1:0] prescale_i,
	input wire logic capture_i,
	// state
	output logic [bsc_pkg::TIM_W-1:0] count_o,
	output logic [bsc_pkg::TIM_W-1:0] zn_o,
	output logic [bsc_pkg::TIM_W-1:0] zprv_o,
	output logic [bsc_pkg::PRE_W-1:0] prescale_o
);
	localparam int TW = bsc_pkg::TIM_W;
	logic [14:0] div_reg, div_next;
	logic [TW-1:0] cnt_next, zn_next, zprv_next;
	logic [bsc_pkg::PRE_W-1:0] ps_next;
	logic [14:0] div_mask;

	always_comb begin
		div_mask = 15'((16'h0001 << prescale_o) - 16'h0001);
		div_next = div_reg + 1'b1;
		cnt_next = count_o;
		zn_next = zn_o;
		zprv_next = zprv_o;
		ps_next = auto_i ? prescale_o : prescale_i;
		if (!run_i) begin
			div_next = '0;
		end else if (capture_i) begin
			zprv_next = zn_o;
			zn_next = count_o;
			cnt_next = bsc_pkg::TIMER_RST;
			div_next = '0;
			if (auto_i && count_o < bsc_pkg::AUTO_LOW &&
			    prescale_o != '0) begin
				ps_next = prescale_o - 1'b1;
			end
		end else if (div_reg >= div_mask) begin
			div_next = '0;
			if (count_o != bsc_pkg::TIMER_TOP) begin
				cnt_next = count_o + 1'b1;
			end else if (auto_i && prescale_o != bsc_pkg::PRESCALE_MAX) begin
				// slower clock, count halved so elapsed time is kept
				ps_next = prescale_o + 1'b1;
				cnt_next = bsc_pkg::AUTO_HALF;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_reg <= '0;
			count_o <= bsc_pkg::TIMER_RST;
			zn_o <= bsc_pkg::TIMER_RST;
			zprv_o <= bsc_pkg::TIMER_RST;
			prescale_o <= bsc_pkg::PRESCALE_RST;
		end else begin
			div_reg <= div_next;
			count_o <= cnt_next;
			zn_o <= zn_next;
			zprv_o <= zprv_next;
			prescale_o <= ps_next;
		end
	end
endmodule : bsc_delay_timer

// File: logic/bsc_top.sv
// top: six-step sequencer, channel manager and safe-state outputs
`timescale 1ns/1ns
module bsc_top (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// sequencer control
	input wire logic RUN_I,
	input wire logic SW_COMMUTE_I,
	input wire logic Z_SIM_I,
	input wire logic D_SIM_I,
	input wire bsc_pkg::bsc_phase_state_s STEP_CFG_I,
	input wire logic [7:0] DELAY_WEIGHT_I,
	input wire logic [7:0] Z_COMPARE_I,
	input wire logic [7:0] D_COMPARE_I,
	// delay timer
	input wire logic TIMER_AUTO_I,
	input wire logic [3:0] TIMER_PRESCALE_I,
	// pwm generator
	input wire logic PWM_CENTER_I,
	input wire logic [11:0] PWM_PERIOD_I,
	input wire logic [7:0] PWM_REPEAT_I,
	input wire logic [35:0] PWM_CMP_PRE_I,
	// channel manager
	input wire logic SINE_MODE_I,
	input wire bsc_pkg::bsc_chan_cfg_s CHAN_CFG_I,
	// safety
	input wire logic SAFE_FORCE_N_I,
	input wire logic ESTOP_N_I,
	input wire logic [1:0] SAFE_STATE_I,
	// sense comparator results
	input wire logic SENSE_INPUT_A_I,
	input wire logic SENSE_INPUT_B_I,
	input wire logic SENSE_INPUT_C_I,
	// status view
	input wire logic REGISTER_PAGE_SELECT_I,
	// drive channels
	output logic [5:0] DRIVE_O,
	output logic [5:0] DRIVE_OE_O,
	// events and status
	output logic PWM_UPDATE_O,
	output logic Z_EVENT_O,
	output logic C_EVENT_O,
	output logic D_EVENT_O,
	output logic MEAS_WINDOW_O,
	output logic [15:0] STATUS_O
);
	localparam int NCH = bsc_pkg::NCH;
	localparam int DW = bsc_pkg::DT_W;

	function automatic logic sense_pick(input logic [1:0] sel,
	                                    input logic [2:0] s);
		logic r;
		r = 1'b0;
		unique case (sel)
			bsc_pkg::SEL_A: r = s[0];
			bsc_pkg::SEL_B: r = s[1];
			bsc_pkg::SEL_C: r = s[2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction : sense_pick

	function automatic logic [7:0] delay_calc(input logic [7:0] t,
	                                          input logic [7:0] w);
		logic [15:0] p;
		p = {8'h00, t} * {8'h00, w};
		return p[15:8];
	endfunction : delay_calc

	// sense synchronisers
	logic [2:0] sense_meta_reg, sense_sync_reg;
	logic sense_prev_reg, sense_prev_next;
	logic sense_now;

	// timer and pwm
	logic [7:0] tim_count, tim_zn, tim_zprv;
	logic [3:0] tim_ps;
	logic [2:0] pwm_ref;
	logic pwm_update;

	// sequencer
	bsc_pkg::bsc_seq_e seq_reg, seq_next;
	bsc_pkg::bsc_phase_state_s phase_reg, phase_next;
	logic [7:0] delay_reg, delay_next;
	logic odd_reg, odd_next;
	logic z_ev, c_ev, d_ev;
	logic z_hit, d_hit, z_hw, d_hw, window;

	// channel manager
	logic [DW-1:0] dt_reg [3];
	logic [DW-1:0] dt_next [3];
	logic [2:0] refd_reg, refd_next;
	logic [7:0] chop_cnt_reg, chop_cnt_next;
	logic chop_clk_reg, chop_clk_next;
	logic [NCH-1:0] drive_reg, drive_next;
	logic [15:0] status_next;
	logic safe;

	bsc_delay_timer u_timer (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.run_i(RUN_I),
		.auto_i(TIMER_AUTO_I),
		.prescale_i(TIMER_PRESCALE_I),
		.capture_i(z_ev),
		.count_o(tim_count),
		.zn_o(tim_zn),
		.zprv_o(tim_zprv),
		.prescale_o(tim_ps)
	);

	bsc_pwm_gen #(
		.W(bsc_pkg::PWM_W)
	) u_pwm (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.center_i(PWM_CENTER_I),
		.period_i(PWM_PERIOD_I),
		.repeat_i(PWM_REPEAT_I),
		.cmp_pre_i(PWM_CMP_PRE_I),
		.ref_o(pwm_ref),
		.update_o(pwm_update)
	);

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			sense_meta_reg <= 3'h0;
			sense_sync_reg <= 3'h0;
			sense_prev_reg <= 1'b0;
		end else begin
			sense_meta_reg <= {SENSE_INPUT_C_I, SENSE_INPUT_B_I,
			                   SENSE_INPUT_A_I};
			sense_sync_reg <= sense_meta_reg;
			sense_prev_reg <= sense_prev_next;
		end
	end

	// detection: window, edge or level, and demag end
	always_comb begin
		// high side off is the only moment the full back-emf is visible
		window = ~pwm_ref[0];
		sense_now = sense_pick(phase_reg.sense_input_select,
		                       sense_sync_reg);
		sense_prev_next = window ? sense_now : sense_prev_reg;
		if (!window) begin
			z_hw = 1'b0;
		end else if (!phase_reg.zero_voltage_detect_mode) begin
			z_hw = phase_reg.zero_cross_edge_polarity ?
			       (sense_now & ~sense_prev_reg) :
			       (~sense_now & sense_prev_reg);
		end else begin
			z_hw = sense_now == phase_reg.zero_cross_edge_polarity;
		end
		z_hit = Z_SIM_I ? (tim_count >= Z_COMPARE_I) : z_hw;
		// demag ends when the winding leaves the rail it started on
		d_hw = sense_now != phase_reg.demag_control_pair[0];
		if (D_SIM_I) begin
			d_hit = tim_count >= D_COMPARE_I;
		end else begin
			d_hit = ~phase_reg.demag_control_pair[1] | d_hw;
		end
	end

	// sequencer
	always_comb begin
		seq_next = seq_reg;
		phase_next = phase_reg;
		delay_next = delay_reg;
		odd_next = odd_reg;
		z_ev = 1'b0;
		c_ev = 1'b0;
		d_ev = 1'b0;
		unique case (seq_reg)
			bsc_pkg::SEQ_IDLE: begin
				phase_next = STEP_CFG_I;
				if (RUN_I) begin
					seq_next = bsc_pkg::SEQ_WAIT_Z;
				end
			end
			bsc_pkg::SEQ_WAIT_Z: begin
				if (z_hit) begin
					z_ev = 1'b1;
					delay_next = delay_calc(tim_count,
					                        DELAY_WEIGHT_I);
					seq_next = bsc_pkg::SEQ_DELAY;
				end
			end
			bsc_pkg::SEQ_DELAY: begin
				if (tim_count >= delay_reg) begin
					c_ev = 1'b1;
				end
			end
			bsc_pkg::SEQ_WAIT_D: begin
				// zero-cross is not looked at until demag has ended
				if (d_hit) begin
					d_ev = 1'b1;
					seq_next = bsc_pkg::SEQ_WAIT_Z;
				end
			end
		endcase
		if (seq_reg != bsc_pkg::SEQ_IDLE && SW_COMMUTE_I) begin
			c_ev = 1'b1;
		end
		if (c_ev) begin
			// step configuration is a preload taken at commutation
			phase_next = STEP_CFG_I;
			odd_next = ~odd_reg;
			seq_next = bsc_pkg::SEQ_WAIT_D;
		end
		// stopping wins over any event of the same cycle
		if (!RUN_I) begin
			seq_next = bsc_pkg::SEQ_IDLE;
			odd_next = odd_reg;
			z_ev = 1'b0;
			c_ev = 1'b0;
			d_ev = 1'b0;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			seq_reg <= bsc_pkg::SEQ_IDLE;
			phase_reg <= '0;
			delay_reg <= bsc_pkg::TIMER_RST;
			odd_reg <= 1'b0;
			Z_EVENT_O <= 1'b0;
			C_EVENT_O <= 1'b0;
			D_EVENT_O <= 1'b0;
		end else begin
			seq_reg <= seq_next;
			phase_reg <= phase_next;
			delay_reg <= delay_next;
			odd_reg <= odd_next;
			Z_EVENT_O <= z_ev;
			C_EVENT_O <= c_ev;
			D_EVENT_O <= d_ev;
		end
	end

	// channel manager
	always_comb begin
		logic pwm_hi;
		logic pwm_lo;
		logic grp_pwm;
		logic six;
		logic sine;
		logic on;
		pwm_hi = 1'b0;
		pwm_lo = 1'b0;
		grp_pwm = 1'b0;
		six = 1'b0;
		sine = 1'b0;
		on = 1'b0;
		refd_next = pwm_ref;
		for (int k = 0; k < 3; k++) begin
			dt_next[k] = dt_reg[k];
			if (pwm_ref[k] != refd_reg[k]) begin
				dt_next[k] = CHAN_CFG_I.deadtime;
			end else if (dt_reg[k] != '0) begin
				dt_next[k] = dt_reg[k] - 1'b1;
			end
		end
		chop_cnt_next = chop_cnt_reg + 1'b1;
		chop_clk_next = chop_clk_reg;
		if (chop_cnt_reg >= CHAN_CFG_I.chop_half_period) begin
			chop_cnt_next = bsc_pkg::CHOP_RST;
			chop_clk_next = ~chop_clk_reg;
		end
		// alternate routing swaps the modulated group every step
		pwm_hi = CHAN_CFG_I.pwm_route[0] &
		         (~CHAN_CFG_I.route_alternate | ~odd_reg);
		pwm_lo = CHAN_CFG_I.pwm_route[1] &
		         (~CHAN_CFG_I.route_alternate | odd_reg);
		for (int n = 0; n < NCH; n++) begin
			grp_pwm = (n % 2 == 0) ? pwm_hi : pwm_lo;
			six = phase_reg.phase_output_enables[n] &
			      (~grp_pwm | pwm_ref[0]);
			if (n % 2 == 0) begin
				sine = refd_reg[n/2] & (dt_reg[n/2] == '0);
			end else begin
				sine = ~refd_reg[n/2] & (dt_reg[n/2] == '0);
			end
			on = SINE_MODE_I ? sine : six;
			if (CHAN_CFG_I.chop_enable) begin
				on = on & chop_clk_reg;
			end
			drive_next[n] = on ^ CHAN_CFG_I.polarity[n];
		end
		if (REGISTER_PAGE_SELECT_I) begin
			status_next = {tim_zprv, tim_ps, odd_reg, 1'b0,
			               seq_reg};
		end else begin
			status_next = {tim_count, tim_zn};
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			for (int k = 0; k < 3; k++) begin
				dt_reg[k] <= bsc_pkg::DT_RST;
			end
			refd_reg <= 3'h0;
			chop_cnt_reg <= bsc_pkg::CHOP_RST;
			chop_clk_reg <= 1'b0;
			drive_reg <= bsc_pkg::PHASE_OE_RST;
			STATUS_O <= 16'h0000;
			PWM_UPDATE_O <= 1'b0;
			MEAS_WINDOW_O <= 1'b0;
		end else begin
			dt_reg <= dt_next;
			refd_reg <= refd_next;
			chop_cnt_reg <= chop_cnt_next;
			chop_clk_reg <= chop_clk_next;
			drive_reg <= drive_next;
			STATUS_O <= status_next;
			PWM_UPDATE_O <= pwm_update;
			MEAS_WINDOW_O <= window;
		end
	end

	// the stop pin acts without any clock, so it bypasses the flops
	assign safe = ~ESTOP_N_I | ~SAFE_FORCE_N_I;
	assign DRIVE_O = !safe ? drive_reg :
	                 (SAFE_STATE_I == bsc_pkg::SAFE_HIGH) ? 6'h3f : 6'h00;
	assign DRIVE_OE_O = (safe && SAFE_STATE_I == bsc_pkg::SAFE_HIZ) ?
	                    6'h00 : 6'h3f;
endmodule : bsc_top

// File: dv/bsc_inverter_model.sv
// inverter legs and windings as seen by the sense comparators
`timescale 1ns/1ns
module bsc_inverter_model (
	// bridge commands
	input wire logic [5:0] drive_i,
	input wire logic [5:0] drive_oe_i,
	// back-emf sign of each winding
	input wire logic [2:0] back_emf_i,
	// comparator results a, b, c
	output logic [2:0] sense_o
);
	// a driven leg pins its terminal to a rail, so only a floating
	// winding shows back-emf and a wrong select sees a flat level
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			if (drive_oe_i[2*p] && drive_i[2*p])
				sense_o[p] = 1'b1;
			else if (drive_oe_i[2*p+1] && drive_i[2*p+1])
				sense_o[p] = 1'b0;
			else
				sense_o[p] = back_emf_i[p];
		end
	end
endmodule : bsc_inverter_model

// File: dv/bsc_top_assertions.sv
// concurrent checks on the six-step block ports
`timescale 1ns/1ns
module bsc_top_assertions (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// watched inputs
	input wire logic RUN_I,
	input wire logic SAFE_FORCE_N_I,
	input wire logic ESTOP_N_I,
	input wire logic [1:0] SAFE_STATE_I,
	input wire bsc_pkg::bsc_chan_cfg_s CHAN_CFG_I,
	// watched outputs
	input wire logic [5:0] DRIVE_O,
	input wire logic [5:0] DRIVE_OE_O,
	input wire logic PWM_UPDATE_O,
	input wire logic Z_EVENT_O,
	input wire logic C_EVENT_O,
	input wire logic D_EVENT_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// last event: 0 none, 1 z, 2 c, 3 d; idle forgets the history
	logic [1:0] last_reg;
	logic [1:0] last_next;
	always_comb begin
		last_next = last_reg;
		if (!RUN_I)
			last_next = 2'h0;
		else if (D_EVENT_O)
			last_next = 2'h3;
		else if (C_EVENT_O)
			last_next = 2'h2;
		else if (Z_EVENT_O)
			last_next = 2'h1;
	end
	always_ff @(posedge CLK_I) begin
		last_reg <= RST_I ? 2'h0 : last_next;
	end
	a_z_after_d: assert property (
		Z_EVENT_O |-> last_reg != 2'h1 && last_reg != 2'h2)
		else $error("zero cross out of order");
	a_d_after_c: assert property (
		D_EVENT_O |-> last_reg == 2'h2)
		else $error("demag end without commutation");
	a_c_delayed: assert property (
		Z_EVENT_O |=> !C_EVENT_O && !Z_EVENT_O)
		else $error("commutation too soon after zero cross");
	a_idle_quiet: assert property (
		!RUN_I && !$past(RUN_I) |-> !(Z_EVENT_O || C_EVENT_O || D_EVENT_O))
		else $error("event while idle");
	a_update_single: assert property (
		PWM_UPDATE_O |=> !PWM_UPDATE_O)
		else $error("update pulse too long");
	a_estop_hiz: assert property (
		!ESTOP_N_I && SAFE_STATE_I == bsc_pkg::SAFE_HIZ |-> DRIVE_OE_O == 6'h00)
		else $error("estop did not float outputs");
	a_estop_low: assert property (
		!ESTOP_N_I && SAFE_STATE_I[0] |-> DRIVE_O == 6'h00 && DRIVE_OE_O == 6'h3f)
		else $error("estop did not pull outputs low");
	a_estop_high: assert property (
		!ESTOP_N_I && SAFE_STATE_I == bsc_pkg::SAFE_HIGH |-> DRIVE_O == 6'h3f)
		else $error("estop did not drive outputs high");
	a_force_high: assert property (
		!SAFE_FORCE_N_I && SAFE_STATE_I == bsc_pkg::SAFE_HIGH |-> DRIVE_O == 6'h3f)
		else $error("software force not high");
	a_no_overlap: assert property (
		ESTOP_N_I && SAFE_FORCE_N_I && $past(ESTOP_N_I) && $past(SAFE_FORCE_N_I)
		&& CHAN_CFG_I.polarity == 6'h00 && $past(CHAN_CFG_I.polarity) == 6'h00
		|-> (DRIVE_O & {DRIVE_O[4:0], 1'b0} & 6'h2a) == 6'h00)
		else $error("both switches of a leg on");
	c_zero_cross: cover property (Z_EVENT_O);
	c_demag_end: cover property (D_EVENT_O);
	c_estop: cover property (!ESTOP_N_I);
endmodule : bsc_top_assertions
bind bsc_top bsc_top_assertions u_bsc_top_assertions (.CLK_I, .RST_I, .RUN_I,
	.SAFE_FORCE_N_I, .ESTOP_N_I, .SAFE_STATE_I, .CHAN_CFG_I, .DRIVE_O,
	.DRIVE_OE_O, .PWM_UPDATE_O, .Z_EVENT_O, .C_EVENT_O, .D_EVENT_O);

// File: dv/tb_bsc_top.sv
// self-checking bench for the six-step commutation block
`timescale 1ns/1ns
module tb_bsc_top;
	logic CLK_I, RST_I, RUN_I, SW_COMMUTE_I, Z_SIM_I, D_SIM_I, SINE_MODE_I;
	logic TIMER_AUTO_I, PWM_CENTER_I, SAFE_FORCE_N_I, ESTOP_N_I;
	logic REGISTER_PAGE_SELECT_I, PWM_UPDATE_O, MEAS_WINDOW_O;
	logic Z_EVENT_O, C_EVENT_O, D_EVENT_O;
	logic [7:0] DELAY_WEIGHT_I, Z_COMPARE_I, D_COMPARE_I, PWM_REPEAT_I;
	logic [3:0] TIMER_PRESCALE_I;
	logic [11:0] PWM_PERIOD_I;
	logic [35:0] PWM_CMP_PRE_I;
	logic [1:0] SAFE_STATE_I;
	logic [5:0] DRIVE_O, DRIVE_OE_O;
	logic [15:0] STATUS_O;
	logic [2:0] back_emf;
	logic [3:0] evs;
	bsc_pkg::bsc_phase_state_s STEP_CFG_I;
	bsc_pkg::bsc_chan_cfg_s CHAN_CFG_I;
	wire logic [2:0] sense;
	wire logic SENSE_INPUT_A_I = sense[0];
	wire logic SENSE_INPUT_B_I = sense[1];
	wire logic SENSE_INPUT_C_I = sense[2];
	int mismatches, comparisons;
	logic [5:0] oo [6] = '{6'h09, 6'h21, 6'h24, 6'h06, 6'h12, 6'h18};
	assign evs = {PWM_UPDATE_O, D_EVENT_O, C_EVENT_O, Z_EVENT_O};

	bsc_top u_bsc_top (.CLK_I, .RST_I, .RUN_I, .SW_COMMUTE_I, .Z_SIM_I,
		.D_SIM_I, .STEP_CFG_I, .DELAY_WEIGHT_I, .Z_COMPARE_I, .D_COMPARE_I,
		.TIMER_AUTO_I, .TIMER_PRESCALE_I, .PWM_CENTER_I, .PWM_PERIOD_I,
		.PWM_REPEAT_I, .PWM_CMP_PRE_I, .SINE_MODE_I, .CHAN_CFG_I,
		.SAFE_FORCE_N_I, .ESTOP_N_I, .SAFE_STATE_I, .SENSE_INPUT_A_I,
		.SENSE_INPUT_B_I, .SENSE_INPUT_C_I, .REGISTER_PAGE_SELECT_I, .DRIVE_O,
		.DRIVE_OE_O, .PWM_UPDATE_O, .Z_EVENT_O, .C_EVENT_O, .D_EVENT_O,
		.MEAS_WINDOW_O, .STATUS_O);
	bsc_inverter_model u_bsc_inverter_model (.drive_i(DRIVE_O),
		.drive_oe_i(DRIVE_OE_O), .back_emf_i(back_emf), .sense_o(sense));

	// step i of the six-step table: enables, select, edge, demag pair
	function automatic bsc_pkg::bsc_phase_state_s step(input int i);
		step = {oo[i], 2'(2 - i % 3), i[0], 1'b0, 1'b1, i[0]};
	endfunction : step
	task automatic tally_and_finish();
		if (mismatches == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge CLK_I);
		#1;
	endtask : tick
	// index 0 z, 1 c, 2 d, 3 update; t is -1 if nothing came
	task automatic wait_ev(input int k, input int n, output int t);
		t = -1;
		for (int i = 0; i < n && t < 0; i++) begin
			tick(1);
			if (evs[k] === 1'b1)
				t = i;
		end
	endtask : wait_ev
	task automatic t_sim_chain();
		int t;
		@(posedge CLK_I);
		STEP_CFG_I <= step(0);
		Z_SIM_I <= 1'b1;
		D_SIM_I <= 1'b1;
		RUN_I <= 1'b1;
		wait_ev(0, 400, t);
		check(t >= 0, "simulated zero cross missing");
		wait_ev(1, 400, t);
		check(t >= 1, "commutation not after delay");
		check(STATUS_O[7:0] === Z_COMPARE_I, "captured z time");
		tick(3);
		check(DRIVE_O === 6'h09, "step one drive pattern");
		wait_ev(2, 400, t);
		check(t >= 0, "simulated demag end missing");
	endtask : t_sim_chain
	task automatic t_steps();
		int t;
		for (int i = 0; i < 6; i++) begin
			@(posedge CLK_I);
			STEP_CFG_I <= step(i);
			CHAN_CFG_I.polarity <= (i == 5) ? 6'h3f : 6'h00;
			wait_ev(1, 600, t);
			tick(3);
			check(DRIVE_O === (i == 5 ? ~oo[i] : oo[i]), "step pattern");
		end
	endtask : t_steps
	task automatic t_hw_zero();
		int t;
		@(posedge CLK_I);
		RUN_I <= 1'b0;
		CHAN_CFG_I.polarity <= 6'h00;
		Z_SIM_I <= 1'b0;
		D_COMPARE_I <= 8'h60;
		STEP_CFG_I <= step(0);
		back_emf <= 3'b100;
		@(posedge CLK_I);
		RUN_I <= 1'b1;
		@(posedge CLK_I);
		SW_COMMUTE_I <= 1'b1;
		@(posedge CLK_I);
		SW_COMMUTE_I <= 1'b0;
		#1;
		check(C_EVENT_O === 1'b1, "software commutation ignored");
		// the long simulated demag must end before the zero cross comes
		wait_ev(2, 200, t);
		check(t >= 0, "demag end after software commutation");
		tick(8);
		back_emf <= 3'b000;
		wait_ev(0, 100, t);
		check(t >= 0, "falling zero cross on c missed");
		STEP_CFG_I <= step(1);
		wait_ev(1, 200, t);
		tick(5);
		back_emf <= 3'b010;
		wait_ev(0, 40, t);
		check(t < 0, "zero cross taken during demag");
		back_emf <= 3'b000;
		wait_ev(2, 200, t);
		check(t >= 0, "demag end missing");
		tick(8);
		back_emf <= 3'b010;
		wait_ev(0, 100, t);
		check(t >= 0, "rising zero cross on b missed");
	endtask : t_hw_zero
	task automatic t_pwm();
		int t;
		@(posedge CLK_I);
		RUN_I <= 1'b0;
		SINE_MODE_I <= 1'b1;
		PWM_REPEAT_I <= 8'h02;
		REGISTER_PAGE_SELECT_I <= 1'b1;
		TIMER_PRESCALE_I <= 4'h3;
		PWM_CMP_PRE_I <= {12'h008, 12'h008, 12'h000};
		repeat (3) wait_ev(3, 100, t);
		check(t + 1 == 48, "update spacing");
		tick(4);
		check(DRIVE_O[1:0] === 2'b10, "zero duty leg");
		check(MEAS_WINDOW_O === 1'b1 && STATUS_O[7:4] === 4'h3,
			"open window or page one view");
		PWM_CMP_PRE_I <= {12'h008, 12'h008, 12'h010};
		tick(6);
		check(DRIVE_O[1:0] === 2'b10, "compare moved before update");
		wait_ev(3, 100, t);
		tick(4);
		check(DRIVE_O[1:0] === 2'b01, "full duty leg");
		check(MEAS_WINDOW_O === 1'b0, "window open at full duty");
		PWM_CENTER_I <= 1'b1;
		wait_ev(3, 300, t);
		check(t >= 0, "center aligned update missing");
	endtask : t_pwm
	task automatic t_chan();
		int t, n0, n5;
		@(posedge CLK_I);
		PWM_CENTER_I <= 1'b0;
		PWM_REPEAT_I <= 8'h00;
		PWM_CMP_PRE_I <= {3{12'h008}};
		CHAN_CFG_I.deadtime <= 8'h03;
		wait_ev(3, 200, t);
		wait_ev(3, 40, t);
		n0 = 0;
		// two 16-cycle periods hold four ref edges of three dead cycles
		for (int i = 0; i < 32; i++) begin
			tick(1);
			n0 += (DRIVE_O[1:0] === 2'b00);
		end
		check(n0 == 12, "deadtime gap");
		SINE_MODE_I <= 1'b0;
		CHAN_CFG_I.pwm_route <= 2'b01;
		for (int c = 0; c < 2; c++) begin
			tick(4);
			n0 = 0;
			n5 = 0;
			for (int i = 0; i < 16; i++) begin
				tick(1);
				n0 += DRIVE_O[0];
				n5 += DRIVE_O[5];
			end
			check(n0 == (c ? 4 : 8) && n5 == (c ? 8 : 16),
				"group routing or chopping");
			CHAN_CFG_I.chop_enable <= 1'b1;
		end
	endtask : t_chan
	task automatic safe_check(input int s);
		check(DRIVE_OE_O === (s == 0 ? 6'h00 : 6'h3f) &&
			(s == 0 || DRIVE_O === (s == 2 ? 6'h3f : 6'h00)), "safe state");
	endtask : safe_check
	task automatic t_safe();
		for (int s = 0; s < 4; s++) begin
			@(posedge CLK_I);
			SAFE_STATE_I <= 2'(s);
			SAFE_FORCE_N_I <= 1'b0;
			tick(1);
			safe_check(s);
			SAFE_FORCE_N_I <= 1'b1;
			ESTOP_N_I <= 1'b0;
			// no clock edge between stop and check: the path is async
			@(negedge CLK_I);
			safe_check(s);
			@(posedge CLK_I);
			ESTOP_N_I <= 1'b1;
		end
	endtask : t_safe

	initial begin
		CLK_I = 1'b0;
		forever #2 CLK_I = ~CLK_I;
	end
	initial begin
		#200000;
		mismatches++;
		tally_and_finish();
	end
	initial begin
		mismatches = 0;
		comparisons = 0;
		{RST_I, SAFE_FORCE_N_I, ESTOP_N_I} = 3'h7;
		{RUN_I, SW_COMMUTE_I, Z_SIM_I, D_SIM_I, SINE_MODE_I} = 5'h00;
		{TIMER_AUTO_I, PWM_CENTER_I, REGISTER_PAGE_SELECT_I} = 3'h0;
		STEP_CFG_I = '0;
		CHAN_CFG_I = '0;
		DELAY_WEIGHT_I = 8'h20;
		Z_COMPARE_I = 8'h10;
		D_COMPARE_I = 8'h20;
		TIMER_PRESCALE_I = 4'h0;
		PWM_PERIOD_I = 12'h00f;
		PWM_REPEAT_I = 8'h00;
		PWM_CMP_PRE_I = {3{12'h008}};
		SAFE_STATE_I = 2'h0;
		back_emf = 3'h0;
		tick(20);
		check(DRIVE_OE_O === 6'h3f && DRIVE_O === 6'h00 &&
			STATUS_O === 16'h0000, "reset outputs");
		RST_I <= 1'b0;
		t_sim_chain();
		t_steps();
		t_hw_zero();
		t_pwm();
		t_chan();
		t_safe();
		tally_and_finish();
	end
endmodule : tb_bsc_top
